// ---- bench/uart_fifo_data_access_ports_tb_top.sv ----
`timescale 1ns/1ps
// ****
// host access port bench
// ****
module uart_fifo_data_access_ports_tb_top;
   import ufd_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic req = 1'h0;
   logic we = 1'h0;
   logic [10:0] addr = 11'h0;
   logic [3:0] be = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [1:0] stall = 2'h0;
   logic busy, ack;
   logic [31:0] rdata, got;
   logic [1:0] tx_valid, tx_ready, rx_valid, rx_ready;
   logic [1:0][7:0] tx_data;
   logic [1:0][15:0] rx_pair;
   logic [7:0] exp_tx[10] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hAA,
      8'hBB, 8'h55, 8'h66, 8'h77, 8'h88};
   int miscompares = 0;
   int comparisons = 0;
   always #2 clk = ~clk;
   ufd_top #(.DEPTH(8)) u_dut (.MCLK_IN(clk), .RST_IN(rst), .REQ_IN(req), .WE_IN(we),
      .ADDR_IN(addr), .BE_IN(be), .WDATA_IN(wdata), .BUSY_OUT(busy), .ACK_OUT(ack),
      .RDATA_OUT(rdata), .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready), .TX_DATA_OUT(tx_data),
      .RX_VALID_IN(rx_valid), .RX_READY_OUT(rx_ready),
      .RX_DATA_IN({rx_pair[1][15:8], rx_pair[0][15:8]}),
      .RX_STATUS_IN({rx_pair[1][7:0], rx_pair[0][7:0]}));
   ufd_serial_model u_far (.clk_in(clk), .stall_in(stall), .tx_valid_in(tx_valid),
      .tx_data_in(tx_data), .tx_ready_out(tx_ready), .rx_ready_in(rx_ready),
      .rx_valid_out(rx_valid), .rx_out(rx_pair));
   task automatic stop_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   // one access; request drops after its taking edge, answer taken in the ack cycle
   task automatic acc(input logic w, input logic [10:0] a, input logic [3:0] b,
                      input logic [31:0] d);
      int n;
      @(negedge clk);
      {req, we, addr, be, wdata} = {1'h1, w, a, b, d};
      @(negedge clk);
      req = 1'h0;
      n = 0;
      while (ack !== 1'h1 && n < 700) begin
         @(negedge clk);
         n++;
      end
      if (n == 700) chk(32'h1, 32'h0);
      got = rdata;
   endtask
   // received byte with its status, status is the inverse so pairs stay distinct
   task automatic rx(input int c, input logic [7:0] d);
      u_far.rx_q[c].push_back({d, ~d});
   endtask
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'h0;
      for (int i = 0; i < 10; i++) rx(0, 8'h10 + i);
      repeat (30) @(negedge clk);
      chk({31'h0, rx_ready[0]}, 32'h0);
      acc(0, BULK_PORT_CH0, 4'hF, 32'h0);
      chk(got, 32'h13121110);
      acc(0, BULK_PORT_CH0 + 11'hFC, 4'hF, 32'h0);
      chk(got, 32'h17161514);
      acc(0, BULK_PORT_CH0, 4'h3, 32'h0);
      chk(got & 32'hFFFF, 32'h1918);
      acc(0, BULK_PORT_CH0, 4'hF, 32'h0);
      chk(got, 32'h0);
      for (int i = 0; i < 4; i++) rx(1, 8'h30 + i);
      for (int i = 1; i < 3; i++) rx(1, 8'h40 + i);
      repeat (12) @(negedge clk);
      acc(0, RX_STATUS_PORT_CH1, 4'hF, 32'h0);
      chk(got, 32'h31CE30CF);
      acc(0, 11'h7FC, 4'h3, 32'h0);
      chk(got & 32'hFFFF, 32'h32CD);
      acc(0, 11'h700, 4'hC, 32'h0);
      chk(got >> 16, 32'h33CC);
      // each byte's status is fixed by the model, so no separate status read
      acc(0, RX_BYTE_PORT_CH1, 4'hF, 32'h0);
      chk(got & 32'hFF, 32'h41);
      acc(0, RX_BYTE_PORT_CH1, 4'h2, 32'h0);
      chk(got & 32'hFF00, 32'h4200);
      acc(1, RX_BYTE_PORT_CH1, 4'h4, 32'h005A0000);
      acc(1, RX_STATUS_PORT_CH0, 4'hF, 32'hDEADBEEF);
      // sink stalls long enough that the third write waits on a full tx fifo
      stall = 2'h1;
      fork
         begin
            repeat (150) @(negedge clk);
            stall = 2'h0;
         end
      join_none
      acc(1, BULK_PORT_CH0, 4'hF, 32'h44332211);
      acc(1, BULK_PORT_CH0, 4'h6, 32'h00BBAA00);
      acc(1, BULK_PORT_CH0, 4'hF, 32'h88776655);
      for (int i = 0; i < 300 && u_far.tx_q[0].size() < 10; i++) @(negedge clk);
      foreach (exp_tx[i]) chk({24'h0, u_far.tx_q[0][i]}, {24'h0, exp_tx[i]});
      chk(u_far.tx_q[0].size(), 32'hA);
      chk(u_far.tx_q[1].size(), 32'h1);
      chk({24'h0, u_far.tx_q[1][0]}, 32'h5A);
      // channel 1 bulk window, upper lanes disabled must push nothing
      acc(1, BULK_PORT_CH1, 4'h3, 32'hFFFFC3B2);
      repeat (10) @(negedge clk);
      chk(u_far.tx_q[1].size(), 32'h3);
      chk({u_far.tx_q[1][2], u_far.tx_q[1][1]}, 32'hC3B2);
      stop_test();
   end
   // the sequence needs well under two thousand cycles
   initial begin
      #40000;
      miscompares++;
      stop_test();
   end
endmodule

// ---- bench/ufd_serial_model.sv ----
`timescale 1ns/1ps
// ****
// serial side stand-in: rx source, tx sink
// ****
module ufd_serial_model (
   input wire logic clk_in,
   input wire logic [1:0] stall_in,
   input wire logic [1:0] tx_valid_in,
   input wire logic [1:0][7:0] tx_data_in,
   output logic [1:0] tx_ready_out,
   input wire logic [1:0] rx_ready_in,
   output logic [1:0] rx_valid_out,
   output logic [1:0][15:0] rx_out
);
   logic [15:0] rx_q[2][$];
   logic [7:0] tx_q[2][$];
   initial begin
      rx_valid_out = 2'h0;
      rx_out = 32'h0;
   end
   // a stalled sink keeps ready low so the design's tx fifo backs up
   assign tx_ready_out = ~stall_in;
   // transfers happen on the edge where both sides agree
   always @(posedge clk_in) begin
      for (int c = 0; c < 2; c++) begin
         if (tx_valid_in[c] && tx_ready_out[c]) tx_q[c].push_back(tx_data_in[c]);
         if (rx_valid_out[c] && rx_ready_in[c]) void'(rx_q[c].pop_front());
      end
   end
   // idle lines toggle so a stale byte never passes for a fresh one
   always @(negedge clk_in) begin
      for (int c = 0; c < 2; c++) begin
         rx_valid_out[c] <= rx_q[c].size() > 0;
         rx_out[c] <= rx_q[c].size() > 0 ? rx_q[c][0] : ~rx_out[c];
      end
   end
endmodule

// ---- bench/ufd_top_sva.sv ----
`timescale 1ns/1ps
// ****
// host access port checks
// ****
module ufd_top_sva
   import ufd_pkg::*;
#(
   parameter int DEPTH = ufd_pkg::FIFO_DEPTH
) (
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic REQ_IN,
   input wire logic WE_IN,
   input wire logic [10:0] ADDR_IN,
   input wire logic [3:0] BE_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic BUSY_OUT,
   input wire logic ACK_OUT,
   input wire logic [31:0] RDATA_OUT,
   input wire logic [1:0] TX_VALID_OUT,
   input wire logic [1:0] TX_READY_IN,
   input wire logic [1:0][7:0] TX_DATA_OUT,
   input wire logic [1:0] RX_VALID_IN,
   input wire logic [1:0] RX_READY_OUT,
   input wire logic [1:0][7:0] RX_DATA_IN,
   input wire logic [1:0][7:0] RX_STATUS_IN
);
   logic take;
   // a request only counts while the port is idle
   assign take = REQ_IN && !BUSY_OUT;
   default clocking @(posedge MCLK_IN);
   endclocking
   default disable iff (RST_IN);
   read_ack_a: assert property (take && !WE_IN |-> ##5 ACK_OUT)
      else $error("read ack not five cycles after take");
   busy_span_a: assert property (take |=> BUSY_OUT [*4])
      else $error("busy dropped early");
   stat_write_a: assert property (take && WE_IN && ADDR_IN[9] |-> ##5 ACK_OUT)
      else $error("status write not acked in five");
   write_done_a: assert property (take && WE_IN |-> ##[5:600] ACK_OUT)
      else $error("write never acked");
   ack_pulse_a: assert property (ACK_OUT |=> !ACK_OUT)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (ACK_OUT |-> $past(BUSY_OUT))
      else $error("ack without busy");
   rdata_hold_a: assert property (ACK_OUT && !take |=> $stable(RDATA_OUT))
      else $error("read data moved");
   tx_hold_a: assert property (TX_VALID_OUT[0] && !TX_READY_IN[0] |=>
      TX_VALID_OUT[0] && $stable(TX_DATA_OUT[0]))
      else $error("tx head dropped while stalled");
   reset_state_a: assert property ($fell(RST_IN) |->
      RX_READY_OUT == 2'h3 && TX_VALID_OUT == 2'h0)
      else $error("fifos not empty after reset");
   cover property (take && !WE_IN && ADDR_IN[9:8] == REGION_STAT_LO);
   cover property (TX_VALID_OUT[0] && !TX_READY_IN[0]);
   cover property (RX_READY_OUT[0] == 1'h0);
endmodule

bind ufd_top ufd_top_sva #(.DEPTH(DEPTH)) u_sva (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN),
   .REQ_IN(REQ_IN), .WE_IN(WE_IN), .ADDR_IN(ADDR_IN), .BE_IN(BE_IN), .WDATA_IN(WDATA_IN),
   .BUSY_OUT(BUSY_OUT), .ACK_OUT(ACK_OUT), .RDATA_OUT(RDATA_OUT), .TX_VALID_OUT(TX_VALID_OUT),
   .TX_READY_IN(TX_READY_IN), .TX_DATA_OUT(TX_DATA_OUT), .RX_VALID_IN(RX_VALID_IN),
   .RX_READY_OUT(RX_READY_OUT), .RX_DATA_IN(RX_DATA_IN), .RX_STATUS_IN(RX_STATUS_IN));

// ---- common/ufd_pkg.sv ----
// ****************************************************************
// uart fifo data access constants
// ****************************************************************
package ufd_pkg;
   // documented fifo depth per direction and channel
   localparam int FIFO_DEPTH = 256;
   localparam int NUM_CH = 2;
   localparam int ADDR_W = 11;
   // channel window: base 0x(4N)00, bulk at 0x(4N+1)00, status at 0x(4N+2)00..0x(4N+3)FF
   localparam logic [10:0] RX_BYTE_PORT_CH0 = 11'h000;
   localparam logic [10:0] BULK_PORT_CH0 = 11'h100;
   localparam logic [10:0] RX_STATUS_PORT_CH0 = 11'h200;
   localparam logic [10:0] RX_BYTE_PORT_CH1 = 11'h400;
   localparam logic [10:0] BULK_PORT_CH1 = 11'h500;
   localparam logic [10:0] RX_STATUS_PORT_CH1 = 11'h600;
   // address field positions
   localparam int CH_BIT = 10;
   localparam int REGION_LSB = 8;
   // region codes taken from address bits [9:8]
   localparam logic [1:0] REGION_BYTE = 2'h0;
   localparam logic [1:0] REGION_BULK = 2'h1;
   localparam logic [1:0] REGION_STAT_LO = 2'h2;
   localparam logic [1:0] REGION_STAT_HI = 2'h3;
   // value returned for a lane when the receive fifo has nothing
   localparam logic [7:0] EMPTY_BYTE = 8'h00;
   localparam logic [1:0] LAST_LANE = 2'h3;

   // access sequencer states, one-hot
   typedef enum logic [1:0] {
      UFD_IDLE = 2'b01,
      UFD_MOVE = 2'b10
   } ufd_state_t;
endpackage

// ---- verilog/ufd_top.sv ----
`timescale 1ns/1ps

// ****************************************************************
// registered-output fifo
// ****************************************************************
module ufd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   // capacity is DEPTH stored words plus the head flop, so DEPTH + 1 in all
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] cnt;
      logic in_ready;
      logic out_valid;
      logic [WIDTH-1:0] out_data;
   } ufdf_state_t;

   ufdf_state_t s_q;
   ufdf_state_t s_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic load;

   // elaboration check: the pointers wrap by overflow, so depth must be a power of two
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
      $error("ufd_fifo: DEPTH must be a power of two of at least 2, WIDTH at least 1");
   end

   // head word lives in a flop so the consumer sees registered outputs;
   // costs one cycle of latency from empty
   always_comb begin
      s_d = s_q;
      push = in_valid_in && s_q.in_ready;
      // pop and refill share an edge, so the head never bubbles while words remain
      load = (s_q.cnt != '0) && (!s_q.out_valid || out_ready_in);
      if (s_q.out_valid && out_ready_in) begin
         s_d.out_valid = 1'b0;
      end
      if (load) begin
         s_d.out_valid = 1'b1;
         s_d.out_data = mem[s_q.rd_ptr];
         s_d.rd_ptr = s_q.rd_ptr + 1'b1;
      end
      if (push) begin
         s_d.wr_ptr = s_q.wr_ptr + 1'b1;
      end
      s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      // ready reflects room for the next cycle, so full is never overrun
      s_d.in_ready = (s_d.cnt < (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '0;
         s_q.in_ready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // storage array, written only on an accepted push
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[s_q.wr_ptr] <= in_data_in;
      end
   end

   // all outputs come straight from the state flops
   assign in_ready_out = s_q.in_ready;
   assign out_valid_out = s_q.out_valid;
   assign out_data_out = s_q.out_data;
endmodule

// ****************************************************************
// host data access ports for two uart channels
// ****************************************************************
// How it works
// - Channel N has a bulk window at 0x(4N+1)00..FF where reads unload rx and writes load tx.
// - A bulk read returns consecutive received bytes, oldest in the lowest lane.
// - A bulk write pushes its bytes into the tx fifo lowest lane first.
// - The status port at 0x200/0x600 returns pairs with data in the upper byte, status below.
// - The status window spans 512 bytes per channel, both halves behaving alike.
// - The bulk windows accept 8, 16, 24 or 32 bit accesses, one byte per enabled lane.
// - 32-bit reads and writes are accepted anywhere in the mapped region.
// - The holding register ports move at most one byte per access, none when no byte lane is enabled.
// - The rx holding register sits at 0x000 and 0x400, and tx holding writes share it.
// - Each channel owns a tx fifo fed by byte and bulk writes and an rx fifo, each holding 257 entries (DEPTH 256 plus the head flop).
module ufd_top
   import ufd_pkg::*;
#(
   parameter int DEPTH = ufd_pkg::FIFO_DEPTH
) (
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic REQ_IN,
   input wire logic WE_IN,
   input wire logic [ufd_pkg::ADDR_W-1:0] ADDR_IN,
   input wire logic [3:0] BE_IN,
   input wire logic [31:0] WDATA_IN,
   output logic BUSY_OUT,
   output logic ACK_OUT,
   output logic [31:0] RDATA_OUT,
   output logic [ufd_pkg::NUM_CH-1:0] TX_VALID_OUT,
   input wire logic [ufd_pkg::NUM_CH-1:0] TX_READY_IN,
   output logic [ufd_pkg::NUM_CH-1:0][7:0] TX_DATA_OUT,
   input wire logic [ufd_pkg::NUM_CH-1:0] RX_VALID_IN,
   output logic [ufd_pkg::NUM_CH-1:0] RX_READY_OUT,
   input wire logic [ufd_pkg::NUM_CH-1:0][7:0] RX_DATA_IN,
   input wire logic [ufd_pkg::NUM_CH-1:0][7:0] RX_STATUS_IN
);
   import ufd_pkg::*;

   typedef struct packed {
      ufd_state_t state;
      logic ch;
      logic [1:0] region;
      logic we;
      logic [3:0] be;
      logic [31:0] wdata;
      logic [1:0] idx;
      logic [31:0] rdata;
      logic ack;
      logic busy;
   } ufd_top_state_t;

   ufd_top_state_t s_q;
   ufd_top_state_t s_d;
   logic [NUM_CH-1:0] tx_push;
   logic [NUM_CH-1:0] tx_ready;
   logic [NUM_CH-1:0] rx_pop;
   logic [NUM_CH-1:0] rx_valid;
   logic [NUM_CH-1:0][15:0] rx_head;
   logic [7:0] tx_byte;
   logic act;

   // elaboration check: the fifos need a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_param
      $error("ufd_top: DEPTH must be a power of two of at least 2");
   end

   // lowest enabled byte lane, used by the holding register port
   // an empty mask falls back to the top lane, which lane_active then ignores
   function automatic logic [1:0] low_lane(input logic [3:0] be);
      logic [1:0] l;
      l = LAST_LANE;
      for (int i = 3; i >= 0; i--) begin
         if (be[i]) begin
            l = 2'(i);
         end
      end
      return l;
   endfunction

   // does this step of the sequencer move a fifo entry
   function automatic logic lane_active(input logic [1:0] region, input logic [3:0] be,
                                        input logic [1:0] idx);
      logic a;
      case (region)
         REGION_BYTE: a = (be != 4'h0) && (idx == low_lane(be));
         REGION_BULK: a = be[idx];
         default: a = !idx[0] && (be[idx] || be[idx + 2'h1]);
      endcase
      return a;
   endfunction

   // ****************************************************************
   // per-channel fifos
   // ****************************************************************
   // fifos per channel
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      // tx entries carry one byte each
      ufd_fifo #(
         .WIDTH(8),
         .DEPTH(DEPTH)
      ) u_tx (
         .clk_in(MCLK_IN),
         .rst_in(RST_IN),
         .in_valid_in(tx_push[c]),
         .in_ready_out(tx_ready[c]),
         .in_data_in(tx_byte),
         .out_valid_out(TX_VALID_OUT[c]),
         .out_ready_in(TX_READY_IN[c]),
         .out_data_out(TX_DATA_OUT[c])
      );
      // rx entries carry the line status with each byte
      ufd_fifo #(
         .WIDTH(16),
         .DEPTH(DEPTH)
      ) u_rx (
         .clk_in(MCLK_IN),
         .rst_in(RST_IN),
         .in_valid_in(RX_VALID_IN[c]),
         .in_ready_out(RX_READY_OUT[c]),
         .in_data_in({RX_STATUS_IN[c], RX_DATA_IN[c]}),
         .out_valid_out(rx_valid[c]),
         .out_ready_in(rx_pop[c]),
         .out_data_out(rx_head[c])
      );
   end

   // ****************************************************************
   // access sequencer
   // ****************************************************************
   // one lane per cycle keeps the fifos single ported; a full access
   // therefore takes four cycles plus any stall on a full tx fifo
   always_comb begin
      s_d = s_q;
      s_d.ack = 1'b0;
      tx_push = '0;
      rx_pop = '0;
      tx_byte = s_q.wdata[8*s_q.idx +: 8];
      act = lane_active(s_q.region, s_q.be, s_q.idx);
      case (s_q.state)
         UFD_IDLE: begin
            // a request is looked at only while idle; the host drops it after
            // the taking edge or it is taken again once the ack has gone out
            // any width taken
            if (REQ_IN) begin
               s_d.state = UFD_MOVE;
               s_d.busy = 1'b1;
               s_d.ch = ADDR_IN[CH_BIT];
               s_d.region = ADDR_IN[REGION_LSB +: 2];
               s_d.we = WE_IN;
               s_d.be = BE_IN;
               s_d.wdata = WDATA_IN;
               s_d.idx = 2'h0;
               // unread lanes come back as zero
               s_d.rdata = 32'h0000_0000;
            end
         end
         UFD_MOVE: begin
            if (act && s_q.we && (s_q.region == REGION_BYTE || s_q.region == REGION_BULK)) begin
               tx_push[s_q.ch] = tx_ready[s_q.ch];
            end else if (act && !s_q.we) begin
               // an empty fifo reads as zero and pops nothing, so a read never stalls
               rx_pop[s_q.ch] = rx_valid[s_q.ch];
               if (s_q.region == REGION_BYTE || s_q.region == REGION_BULK) begin
                  s_d.rdata[8*s_q.idx +: 8] = rx_valid[s_q.ch] ? rx_head[s_q.ch][7:0]
                                                              : EMPTY_BYTE;
               end else begin
                  // status low, data high
                  // pairs sit at lanes 1:0 or 3:2, picked by the upper index bit
                  s_d.rdata[16*s_q.idx[1] +: 16] = rx_valid[s_q.ch] ?
                     {rx_head[s_q.ch][7:0], rx_head[s_q.ch][15:8]} : {EMPTY_BYTE, EMPTY_BYTE};
               end
            end
            // writes to the status window match neither branch: acked, nothing moved
            // stall only on full tx
            if (!(act && s_q.we && (s_q.region == REGION_BYTE || s_q.region == REGION_BULK)
                  && !tx_ready[s_q.ch])) begin
               s_d.idx = s_q.idx + 2'h1;
               if (s_q.idx == LAST_LANE) begin
                  s_d.state = UFD_IDLE;
                  s_d.busy = 1'b0;
                  s_d.ack = 1'b1;
               end
            end
         end
         default: begin
            s_d.state = UFD_IDLE;
            s_d.busy = 1'b0;
         end
      endcase
   end

   // state register, synchronous reset
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         s_q <= '0;
         s_q.state <= UFD_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign BUSY_OUT = s_q.busy;
   assign ACK_OUT = s_q.ack;
   assign RDATA_OUT = s_q.rdata;
endmodule
